// >>> hw/irq_pkg.sv
// package: constants and types of the interrupt priority resolver
`default_nettype none
package irq_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int          AW           = 8;
  localparam int          NREG         = 12;
  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  PRIO_A_OFS   = 8'h04;
  localparam logic [7:0]  PRIO_B_OFS   = 8'h08;
  localparam logic [7:0]  VEC_A_OFS    = 8'h0C;
  localparam logic [7:0]  VEC_B_OFS    = 8'h10;
  localparam logic [7:0]  VEC_C_OFS    = 8'h14;
  localparam logic [7:0]  VEC_D_OFS    = 8'h18;
  localparam logic [7:0]  VEC_WD_OFS   = 8'h1C;
  localparam logic [7:0]  VEC_DIV_OFS  = 8'h20;
  localparam logic [7:0]  VEC_DMA0_OFS = 8'h24;
  localparam logic [7:0]  VEC_DMA1_OFS = 8'h28;
  localparam logic [7:0]  VBASE_OFS    = 8'h2C;
  localparam logic [7:0]  STAT_OFS     = 8'h30;
  localparam logic [31:0] REG_RESET    = 32'h0000_0000;
  // writable bits per register index
  localparam logic [31:0] WMASK [NREG] = '{
    32'h0000_0101, 32'h0000_FFF0, 32'h0000_FF00, 32'h0000_7F7F,
    32'h0000_7F7F, 32'h0000_7F7F, 32'h0000_7F00, 32'h0000_7F7F,
    32'h0000_007F, 32'h0000_007F, 32'h0000_007F, 32'hFFFF_FFFC};
  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_NMI_LVL_BIT = 15;
  localparam int CTRL_EDGE_BIT    = 8;
  localparam int CTRL_MODE_BIT    = 0;
  localparam int PRIO_DIV_LSB     = 12;
  localparam int PRIO_DMA_LSB     = 8;
  localparam int PRIO_WD_LSB      = 4;
  localparam int PRIO_SER_LSB     = 12;
  localparam int PRIO_FRT_LSB     = 8;
  localparam int VEC_HI_LSB       = 8;
  localparam int VEC_LO_LSB       = 0;
  // ****************************************
  // fixed levels, vectors and timing
  // ****************************************
  localparam logic [4:0] LVL_NMI        = 5'h10;
  localparam logic [4:0] LVL_BRK        = 5'h0F;
  localparam logic [3:0] MASK_FIXED     = 4'hF;
  localparam logic [6:0] VEC_NMI        = 7'h0B;
  localparam logic [6:0] VEC_BRK        = 7'h0C;
  localparam logic [6:0] AUTO_VEC_BASE  = 7'h40;
  localparam logic [3:0] IRL_NONE       = 4'hF;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_DECERR    = 2'h3;
  localparam int         NSRC           = 15;
  localparam int         SRC_NMI        = 0;
  localparam int         SRC_IRL        = 2;
  localparam int         FETCH_SETTLE   = 3;

  typedef struct packed {
    logic div_ovf;
    logic dma0;
    logic dma1;
    logic interval;
    logic cmp_match;
    logic rx_err;
    logic rx_full;
    logic tx_empty;
    logic tx_end;
    logic capture;
    logic compare;
    logic tmr_ovf;
  } periph_req_t;

  typedef struct packed {
    logic [4:0] level;
    logic [6:0] vector;
  } cand_t;

  typedef struct packed {
    logic [3:0]  new_mask;
    logic [6:0]  vector;
    logic [31:0] handler_addr;
  } accept_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_DONE  = 3'b100
  } state_t;
endpackage
`default_nettype wire

// >>> hw/pin_sync.sv
// module: two-flop synchroniser for pin inputs
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // system clock
  input  wire logic         rst,   // async reset
  input  wire logic [W-1:0] d,     // asynchronous pin level
  output logic      [W-1:0] q      // synchronised level
);
  logic [W-1:0] meta_q;

  // a zero-wide synchroniser would silently drop every pin
  if (W < 1) begin : g_width_check
    $error("pin_sync needs at least one bit");
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> hw/interrupt_priority_resolver.sv
// module: interrupt priority resolver with AXI4-Lite register access
`default_nettype none
module interrupt_priority_resolver
  import irq_pkg::*;
(
  input  wire logic          clk,                    // system clock
  input  wire logic          rst,                    // async reset, high
  input  wire logic [AW-1:0] s_axi_awaddr,           // write address
  input  wire logic          s_axi_awvalid,          // write address valid
  output logic               s_axi_awready,          // write address ready
  input  wire logic [31:0]   s_axi_wdata,            // write data
  input  wire logic [3:0]    s_axi_wstrb,            // byte strobes
  input  wire logic          s_axi_wvalid,           // write data valid
  output logic               s_axi_wready,           // write data ready
  output logic [1:0]         s_axi_bresp,            // write response
  output logic               s_axi_bvalid,           // write response valid
  input  wire logic          s_axi_bready,           // write response ready
  input  wire logic [AW-1:0] s_axi_araddr,           // read address
  input  wire logic          s_axi_arvalid,          // read address valid
  output logic               s_axi_arready,          // read address ready
  output logic [31:0]        s_axi_rdata,            // read data
  output logic [1:0]         s_axi_rresp,            // read response
  output logic               s_axi_rvalid,           // read data valid
  input  wire logic          s_axi_rready,           // read data ready
  input  wire logic          nmi_pin,                // nonmaskable pin
  input  wire logic [3:0]    level_request_lines,    // encoded level pins
  input  wire logic [7:0]    vector_number_inputs,   // external vector pins
  input  wire logic          wait_n_pin,             // wait pin, low stretches
  input  wire logic [3:0]    bus_cs_n,               // chip selects from bus unit
  output logic [3:0]         chip_select_lines,      // chip select pins
  output logic [3:0]         accepted_level_outputs, // accepted level pins
  output logic               vector_fetch_strobe,    // external fetch cycle
  input  wire logic          break_req,              // break unit request
  input  wire periph_req_t   periph_req,             // on-chip module requests
  input  wire logic [3:0]    sr_mask_level,          // current core mask
  output logic               irq_request,            // request to core
  input  wire logic          irq_ack,                // core takes request
  output logic               accept_valid,           // acceptance result pulse
  output accept_t            accept                  // new mask, vector, address
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [13:0] pins_s;
  logic        nmi_s;
  logic        wait_n_s;
  logic [3:0]  irl_s;
  logic [7:0]  ext_vec_s;

  pin_sync #(.W(14)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({nmi_pin, wait_n_pin, level_request_lines, vector_number_inputs}),
    .q   (pins_s)
  );
  assign {nmi_s, wait_n_s, irl_s, ext_vec_s} = pins_s;

  // ****************************************
  // register file
  // ****************************************
  logic [31:0]   regs_q [NREG];
  logic          aw_got_q, w_got_q, wr_fire;
  logic [AW-1:0] awaddr_q, wr_addr;
  logic [31:0]   wdata_q, wr_data;
  logic [3:0]    wstrb_q, wr_strb;
  function automatic logic mapped(input logic [AW-1:0] a);
    return (a[1:0] == 2'b00) && (a <= STAT_OFS);
  endfunction
  function automatic int unsigned reg_index(input logic [AW-1:0] a);
    return int'(a[AW-1:2]);
  endfunction
  function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] st, input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r & m;
  endfunction
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  assign wr_addr = aw_got_q ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_got_q ? wdata_q : s_axi_wdata;
  assign wr_strb = w_got_q ? wstrb_q : s_axi_wstrb;
  assign wr_fire = (aw_got_q || (s_axi_awvalid && s_axi_awready))
                && (w_got_q || (s_axi_wvalid && s_axi_wready));
  // write address and data may arrive in either order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (mapped(wr_addr) && wr_addr != STAT_OFS) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // reserved bits stay zero through the write mask
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else if (wr_fire && mapped(wr_addr) && wr_addr != STAT_OFS) begin
      regs_q[reg_index(wr_addr)] <= strobe_merge(regs_q[reg_index(wr_addr)], wr_data, wr_strb,
                                                 WMASK[reg_index(wr_addr)]);
    end
  end

  // ****************************************
  // register fields
  // ****************************************
  logic [31:0] prio_a, prio_b, vec_a, vec_b, vec_c, vec_d, vec_wd, vbase;
  logic        edge_rise_sel, ext_mode;

  assign edge_rise_sel = regs_q[reg_index(CTRL_OFS)][CTRL_EDGE_BIT];
  assign ext_mode      = regs_q[reg_index(CTRL_OFS)][CTRL_MODE_BIT];
  assign prio_a = regs_q[reg_index(PRIO_A_OFS)];
  assign prio_b = regs_q[reg_index(PRIO_B_OFS)];
  assign vec_a  = regs_q[reg_index(VEC_A_OFS)];
  assign vec_b  = regs_q[reg_index(VEC_B_OFS)];
  assign vec_c  = regs_q[reg_index(VEC_C_OFS)];
  assign vec_d  = regs_q[reg_index(VEC_D_OFS)];
  assign vec_wd = regs_q[reg_index(VEC_WD_OFS)];
  assign vbase  = regs_q[reg_index(VBASE_OFS)];

  // ****************************************
  // nonmaskable edge detection
  // ****************************************
  logic       nmi_prev_q, nmi_pend_q;
  logic [2:0] arm_q;
  logic       nmi_edge, nmi_taken;
  // arm only once the last-level flop holds a real pin level, so a pin idling high fakes no edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arm_q      <= 3'b000;
      nmi_prev_q <= 1'b0;
    end else begin
      arm_q      <= {arm_q[1:0], 1'b1};
      nmi_prev_q <= nmi_s;
    end
  end
  assign nmi_edge = arm_q[2] && (edge_rise_sel ? (nmi_s && !nmi_prev_q)
                                               : (!nmi_s && nmi_prev_q));
  // a new edge in the acceptance cycle wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nmi_pend_q <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend_q <= 1'b1;
    end else if (nmi_taken) begin
      nmi_pend_q <= 1'b0;
    end
  end

  // ****************************************
  // candidates and resolution
  // ****************************************
  cand_t       cand [NSRC];
  logic [4:0]  irl_level;
  logic [3:0]  p_div, p_dma, p_wd, p_ser, p_frt;
  assign irl_level = 5'(IRL_NONE - irl_s);
  assign p_div = prio_a[PRIO_DIV_LSB +: 4];
  assign p_dma = prio_a[PRIO_DMA_LSB +: 4];
  assign p_wd  = prio_a[PRIO_WD_LSB +: 4];
  assign p_ser = prio_b[PRIO_SER_LSB +: 4];
  assign p_frt = prio_b[PRIO_FRT_LSB +: 4];
  function automatic cand_t mk(input logic req, input logic [3:0] lvl, input logic [6:0] v);
    cand_t c;
    c.level  = req ? {1'b0, lvl} : 5'h00;
    c.vector = v;
    return c;
  endfunction
  // list order is the default and within-field order; modules sharing a field share its level
  always_comb begin
    cand[0].level  = nmi_pend_q ? LVL_NMI : 5'h00;
    cand[0].vector = VEC_NMI;
    cand[1].level  = break_req ? LVL_BRK : 5'h00;
    cand[1].vector = VEC_BRK;
    cand[2].level  = irl_level;
    cand[2].vector = 7'(AUTO_VEC_BASE + 7'(irl_level[3:1]));
    cand[3]  = mk(periph_req.div_ovf,   p_div, regs_q[reg_index(VEC_DIV_OFS)][6:0]);
    cand[4]  = mk(periph_req.dma0,      p_dma, regs_q[reg_index(VEC_DMA0_OFS)][6:0]);
    cand[5]  = mk(periph_req.dma1,      p_dma, regs_q[reg_index(VEC_DMA1_OFS)][6:0]);
    cand[6]  = mk(periph_req.interval,  p_wd,  vec_wd[VEC_HI_LSB +: 7]);
    cand[7]  = mk(periph_req.cmp_match, p_wd,  vec_wd[VEC_LO_LSB +: 7]);
    cand[8]  = mk(periph_req.rx_err,    p_ser, vec_a[VEC_HI_LSB +: 7]);
    cand[9]  = mk(periph_req.rx_full,   p_ser, vec_a[VEC_LO_LSB +: 7]);
    cand[10] = mk(periph_req.tx_empty,  p_ser, vec_b[VEC_HI_LSB +: 7]);
    cand[11] = mk(periph_req.tx_end,    p_ser, vec_b[VEC_LO_LSB +: 7]);
    cand[12] = mk(periph_req.capture,   p_frt, vec_c[VEC_HI_LSB +: 7]);
    cand[13] = mk(periph_req.compare,   p_frt, vec_c[VEC_LO_LSB +: 7]);
    cand[14] = mk(periph_req.tmr_ovf,   p_frt, vec_d[VEC_HI_LSB +: 7]);
  end
  cand_t win;
  int    win_idx;
  // strict compare keeps the earlier source on a tie
  always_comb begin
    win     = '0;
    win_idx = 0;
    for (int i = 0; i < NSRC; i++) begin
      if (cand[i].level > win.level) begin
        win     = cand[i];
        win_idx = i;
      end
    end
  end

  // level 0 never passes; pending requests wait until they beat the mask
  assign irq_request = (win.level == LVL_NMI)
                    || (win.level != 5'h00 && win.level > {1'b0, sr_mask_level});

  // ****************************************
  // acceptance sequence
  // ****************************************
  state_t      state_q;
  logic [1:0]  settle_q;
  logic [3:0]  acc_mask_q;
  logic [6:0]  acc_vec_q;
  logic        take;
  assign take      = (state_q == ST_IDLE) && irq_ack && irq_request;
  assign nmi_taken = take && (win_idx == SRC_NMI);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      settle_q   <= 2'b00;
      acc_mask_q <= 4'h0;
      acc_vec_q  <= 7'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            acc_vec_q  <= win.vector;
            settle_q   <= 2'b00;
            acc_mask_q <= (win.level[4] || win_idx < SRC_IRL) ? MASK_FIXED
                                                            : win.level[3:0];
            state_q    <= (win_idx == SRC_IRL && ext_mode) ? ST_FETCH : ST_DONE;
          end
        end
        ST_FETCH: begin
          // the settle count covers the synchroniser delay of the vector pins
          if (settle_q != 2'(FETCH_SETTLE - 1)) begin
            settle_q <= 2'(settle_q + 2'b01);
          end else if (wait_n_s) begin
            acc_vec_q <= ext_vec_s[6:0];
            state_q   <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // fetch pins: level out, strobe, chip selects forced inactive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accepted_level_outputs <= 4'h0;
      vector_fetch_strobe    <= 1'b0;
    end else begin
      accepted_level_outputs <= (take && win_idx == SRC_IRL && ext_mode) ? win.level[3:0]
                              : (state_q == ST_FETCH && !(settle_q == 2'(FETCH_SETTLE - 1) && wait_n_s))
                                ? accepted_level_outputs : 4'h0;
      vector_fetch_strobe    <= (take && win_idx == SRC_IRL && ext_mode)
                             || (state_q == ST_FETCH && !(settle_q == 2'(FETCH_SETTLE - 1) && wait_n_s));
    end
  end

  assign chip_select_lines = vector_fetch_strobe ? 4'hF : bus_cs_n;

  // result handed to the core one cycle per acceptance
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accept_valid <= 1'b0;
      accept       <= '0;
    end else begin
      accept_valid <= (state_q == ST_DONE);
      if (state_q == ST_DONE) begin
        accept.new_mask     <= acc_mask_q;
        accept.vector       <= acc_vec_q;
        accept.handler_addr <= vbase + {23'h00_0000, acc_vec_q, 2'b00};
      end
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == STAT_OFS) begin
      rd_word = {13'h0000, nmi_pend_q, irq_request, win.level, acc_mask_q, 1'b0, acc_vec_q};
    end else if (mapped(s_axi_araddr)) begin
      rd_word = regs_q[reg_index(s_axi_araddr)];
      if (s_axi_araddr == CTRL_OFS) begin
        rd_word[CTRL_NMI_LVL_BIT] = nmi_s;
      end
    end
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/irq_monitor.sv
// checker: concurrent properties on the resolver ports
`default_nettype none
module irq_monitor
  import irq_pkg::*;
(
  input wire logic       clk,                    // system clock
  input wire logic       rst,                    // async reset
  input wire logic [3:0] bus_cs_n,               // chip selects in
  input wire logic [3:0] chip_select_lines,      // chip selects out
  input wire logic [3:0] accepted_level_outputs, // fetch level
  input wire logic       vector_fetch_strobe,    // fetch cycle
  input wire logic       accept_valid,           // accept pulse
  input wire accept_t    accept                  // accept result
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_cs_high: assert property (vector_fetch_strobe |-> chip_select_lines == 4'hF)
    else $error("chip select active in fetch");
  a_cs_pass: assert property (!vector_fetch_strobe |-> chip_select_lines == bus_cs_n)
    else $error("chip select not passed");
  a_level_idle: assert property (!vector_fetch_strobe |-> accepted_level_outputs == 4'h0)
    else $error("level shown outside fetch");
  a_level_shown: assert property (vector_fetch_strobe |-> accepted_level_outputs != 4'h0)
    else $error("no level in fetch");
  a_fetch_min: assert property ($rose(vector_fetch_strobe) |-> vector_fetch_strobe[*3])
    else $error("fetch too short");
  a_fetch_done: assert property ($fell(vector_fetch_strobe) |=> accept_valid)
    else $error("no accept after fetch");
  a_fetch_mask: assert property ($fell(vector_fetch_strobe) |=>
    accept.new_mask == $past(accepted_level_outputs, 2))
    else $error("mask differs from fetched level");
  a_fetch_quiet: assert property (vector_fetch_strobe |-> !accept_valid)
    else $error("accept during fetch");
  a_accept_hold: assert property (!accept_valid |-> $stable(accept) && accept.handler_addr[1:0] == 2'b00)
    else $error("accept result moved");
  c_fetch: cover property ($fell(vector_fetch_strobe));
  c_nmi: cover property (accept_valid && accept.vector == VEC_NMI);
  c_brk: cover property (accept_valid && accept.vector == VEC_BRK);
endmodule

bind interrupt_priority_resolver irq_monitor mon (.clk, .rst, .bus_cs_n, .chip_select_lines,
  .accepted_level_outputs, .vector_fetch_strobe, .accept_valid, .accept);
`default_nettype wire

// >>> testbench/irq_vector_source.sv
// model: external vector source and wait generator on the fetch pins
`default_nettype none
module irq_vector_source (
  input  wire logic       clk,                    // system clock
  input  wire logic       rst,                    // async reset
  input  wire logic       vector_fetch_strobe,    // fetch cycle
  input  wire logic [3:0] accepted_level_outputs, // fetched level
  input  wire logic [6:0] vec,                    // vector to supply
  input  wire logic [3:0] stretch,                // wait cycles per fetch
  output logic      [7:0] vector_number_inputs,   // vector pins
  output logic            wait_n_pin              // wait pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] junk_q;
  logic [3:0] cnt_q;
  // off the fetch the data lines carry other traffic, so they toggle every cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      junk_q <= 8'h5A;
      cnt_q  <= 4'h0;
    end else begin
      junk_q <= ~junk_q;
      cnt_q  <= vector_fetch_strobe ? cnt_q + {3'h0, cnt_q != stretch} : 4'h0;
    end
  end
  assign vector_number_inputs = (vector_fetch_strobe && accepted_level_outputs != 4'h0) ? {1'b0, vec} : junk_q;
  assign wait_n_pin = !(vector_fetch_strobe && cnt_q != stretch);
endmodule
`default_nettype wire

// >>> testbench/interrupt_priority_resolver_bench.sv
// bench: register access, arbitration and vector fetch sequences
`default_nettype none
module interrupt_priority_resolver_bench import irq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk = 1'b0, rst = 1'b1, irq_ack = 1'b0, nmi_pin = 1'b0, break_req = 1'b0;
  logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic          s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic          irq_request, accept_valid, vector_fetch_strobe, wait_n_pin;
  logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]   s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]    s_axi_wstrb = 4'hF, bus_cs_n = 4'h5, level_request_lines = 4'hF, sr_mask_level = 4'h0;
  logic [3:0]    stretch = 4'h0, chip_select_lines, accepted_level_outputs;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic [7:0]    vector_number_inputs;
  logic [6:0]    vec = 7'h0;
  periph_req_t   periph_req = '0;
  accept_t       accept;
  int            n_fail = 0, compares = 0;

  interrupt_priority_resolver uut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nmi_pin,
    .level_request_lines, .vector_number_inputs, .wait_n_pin, .bus_cs_n, .chip_select_lines,
    .accepted_level_outputs, .vector_fetch_strobe, .break_req, .periph_req, .sr_mask_level, .irq_request,
    .irq_ack, .accept_valid, .accept);
  irq_vector_source far (.clk, .rst, .vector_fetch_strobe, .accepted_level_outputs, .vec, .stretch,
    .vector_number_inputs, .wait_n_pin);

  initial forever #20 clk = ~clk;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er, "bresp");
    // let an edge pass so a following call never re-raises bready in the same step
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp, "rdata");
    chk(s_axi_rresp, er, "rresp");
    @(posedge clk);
  endtask

  // core side: wait for a request, take it, check the result
  task automatic take(input logic [3:0] m, input logic [6:0] v);
    do @(posedge clk); while (irq_request !== 1'b1);
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
    do @(posedge clk); while (accept_valid !== 1'b1);
    chk(accept.new_mask, m, "mask");
    chk(accept.vector, v, "vector");
    chk(accept.handler_addr, 32'h0000_1000 + {v, 2'b00}, "handler");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(CTRL_OFS, 32'h0, RESP_OKAY);
    rd(PRIO_A_OFS, 32'h0, RESP_OKAY);
    rd(PRIO_B_OFS, 32'h0, RESP_OKAY);
    wr(PRIO_A_OFS, 32'hFFFF_FFFF, RESP_OKAY);
    rd(PRIO_A_OFS, 32'h0000_FFF0, RESP_OKAY);
    wr(VEC_A_OFS, 32'hFFFF_FFFF, RESP_OKAY);
    rd(VEC_A_OFS, 32'h0000_7F7F, RESP_OKAY);
    wr(STAT_OFS, 32'h0, RESP_DECERR);
    rd(8'h34, 32'h0, RESP_DECERR);
    wr(PRIO_A_OFS, 32'h0, RESP_OKAY);
    wr(VBASE_OFS, 32'h0000_1000, RESP_OKAY);
    periph_req.div_ovf <= 1'b1;
    repeat (4) @(posedge clk);
    chk(irq_request, 1'b0, "masked");
    for (int c = 0; c < 15; c++) begin
      sr_mask_level <= 4'(15 - c);
      level_request_lines <= 4'(c);
      repeat (4) @(posedge clk);
      chk(irq_request, 1'b0, "at mask");
      sr_mask_level <= 4'(14 - c);
      take(4'(15 - c), 7'(64 + (15 - c) / 2));
    end
    level_request_lines <= IRL_NONE;
    wr(PRIO_A_OFS, 32'h0000_7700, RESP_OKAY);
    wr(VEC_DIV_OFS, 32'h0000_0030, RESP_OKAY);
    wr(VEC_DMA0_OFS, 32'h0000_0021, RESP_OKAY);
    wr(VEC_DMA1_OFS, 32'h0000_0022, RESP_OKAY);
    periph_req.dma0 <= 1'b1;
    periph_req.dma1 <= 1'b1;
    sr_mask_level <= 4'h6;
    take(4'h7, 7'h30);
    periph_req.div_ovf <= 1'b0;
    take(4'h7, 7'h21);
    periph_req.dma0 <= 1'b0;
    take(4'h7, 7'h22);
    periph_req <= '0;
    sr_mask_level <= 4'h0;
    break_req <= 1'b1;
    level_request_lines <= 4'h0;
    repeat (4) @(posedge clk);
    take(MASK_FIXED, VEC_BRK);
    break_req <= 1'b0;
    take(4'hF, 7'd71);
    level_request_lines <= IRL_NONE;
    wr(CTRL_OFS, 32'h0000_0100, RESP_OKAY);
    sr_mask_level <= 4'hF;
    nmi_pin <= 1'b1;
    repeat (3) @(posedge clk);
    nmi_pin <= 1'b0;
    take(MASK_FIXED, VEC_NMI);
    repeat (6) @(posedge clk);
    chk(irq_request, 1'b0, "falling edge");
    wr(CTRL_OFS, 32'h0000_0001, RESP_OKAY);
    sr_mask_level <= 4'h0;
    vec <= 7'h55;
    stretch <= 4'h4;
    level_request_lines <= 4'h3;
    take(4'hC, 7'h55);
    sr_mask_level <= 4'hF;
    nmi_pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk(irq_request, 1'b0, "rising edge");
    nmi_pin <= 1'b0;
    take(MASK_FIXED, VEC_NMI);
    summarize;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize;
  end
endmodule
`default_nettype wire
